// [hbw_pkg.sv]
// Shared constants and carrier types of the host bus width and word swap
// block.
// Assumes one 20 MHz core clock and a byte address of HBW_ADDR_W bits.
package hbw_pkg;

    // Host byte address width and the dword address derived from it.
    localparam int HBW_ADDR_W = 8;
    localparam int HBW_DW_ADDR_W = HBW_ADDR_W - 2;

    // Position of the bus width flag in the hardware configuration word.
    localparam int HARDWARE_CONFIG_REG_WIDTH_BIT = 2;

    // Strap level that selects the 16-bit host bus.
    localparam logic STRAP_16_LEVEL = 1'b1;

    // Word swap control value that selects the swapped mapping.
    localparam logic [31:0] SWAP_ALL_ONES = 32'hFFFFFFFF;

    // Reset value of the data holders and the read answer, and the answer to a repeated half read.
    localparam logic [31:0] DWORD_RESET = 32'h00000000;
    localparam logic [15:0] HALF_INVALID = 16'h0000;

    // Clock period in ns, kept for anyone deriving a time from it.
    localparam int CLK_PERIOD_NS = 50;

    // One dword travelling from the host port to the core.
    typedef struct packed {
        logic [HBW_DW_ADDR_W-1:0] dw_addr;
        logic [31:0] data;
    } hbw_wr_ent_t;

    // Serialiser states toward the network side.
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_LOW,
        TX_HIGH
    } hbw_tx_state_t;

endpackage : hbw_pkg

// [hbw_host_port.sv]
// Host data path: bus width strap, half-word pairing, word swap lanes,
// a write buffer toward the core and the network word ordering.
// Assumes synchronous host strobes of one cycle and a core that answers a
// read address combinationally in the same cycle.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Strap level picks 32-bit or 16-bit bus; 32-bit needs no pairing.
// - Strapped width shows read-only at bit 2 of hardware config word.
// - Either half may come first; the next goes to the other half.
// - A second write to the same unpaired half is discarded.
// - Repeated half read returns invalid data and restarts read tracking.
// - Upper data lines are never driven in 16-bit mode.
// - Word swap acts only in 16-bit mode; ignored in 32-bit mode.
// - Swap mapping applies to every half-word register and FIFO access.
// - Only an all-ones swap control selects swapping; else default.
// - Default: address bit 1 low is low word, high is high word.
// - Swapped: address bit 1 low is high word, high is low word.
// - Network transmit sends the low word of each dword first.
// - First received network word lands in the low dword half.
module hbw_host_port #(
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Strap and configuration.
    input wire logic width_strap_pin,
    input wire logic [31:0] word_swap_reg,
    output logic [31:0] hardware_config_reg,
    // Host bus.
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [hbw_pkg::HBW_ADDR_W-1:0] host_addr,
    input wire logic [31:0] host_d_in,
    output logic host_wr_ready,
    output logic [31:0] host_d_out,
    output logic host_d_oe_lo,
    output logic host_d_oe_hi,
    output logic host_rd_ack,
    // Core write side.
    output logic core_wr_valid,
    input wire logic core_wr_ready,
    output hbw_pkg::hbw_wr_ent_t core_wr_ent,
    // Core read side.
    output logic [hbw_pkg::HBW_DW_ADDR_W-1:0] core_rd_addr,
    input wire logic [31:0] core_rd_data,
    // Network transmit side.
    input wire logic tx_dw_valid,
    output logic tx_dw_ready,
    input wire logic [31:0] tx_dw,
    output logic tx_hw_valid,
    input wire logic tx_hw_ready,
    output logic [15:0] tx_hw,
    // Network receive side.
    input wire logic rx_hw_valid,
    input wire logic [15:0] rx_hw,
    output logic rx_dw_valid,
    output logic [31:0] rx_dw
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Advance a buffer pointer with wrap.
    function automatic logic [PTR_W-1:0] step_ptr(input logic [PTR_W-1:0] p);
        step_ptr = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : step_ptr

    // Internal half addressed by a host half-word access.
    function automatic logic pick_high(input logic a1, input logic swap);
        pick_high = a1 ^ swap;
    endfunction : pick_high

    ////////////////////////////////////////////////////////////////////////
    // Strap capture and mode decode.

    logic strap_done_ff, nxt_strap_done;
    logic width16_ff, nxt_width16;
    logic swap;
    logic wr_go, rd_go, hi_sel;

    // The strap is caught at the first edge after release, never by reset.
    always_comb begin
        nxt_strap_done = 1'b1;
        nxt_width16 = strap_done_ff ? width16_ff
            : (width_strap_pin == hbw_pkg::STRAP_16_LEVEL);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_done_ff <= 1'b0;
            width16_ff <= 1'b0;
        end else begin
            strap_done_ff <= nxt_strap_done;
            width16_ff <= nxt_width16;
        end
    end

    // Swap is honoured only on the narrow bus and only for all ones.
    assign swap = width16_ff
        && (word_swap_reg == hbw_pkg::SWAP_ALL_ONES);
    assign hi_sel = pick_high(host_addr[1], swap);
    assign hardware_config_reg = {29'h0, width16_ff, 2'h0};
    assign wr_go = host_wr && host_wr_ready;
    assign rd_go = host_rd;
    assign core_rd_addr = host_addr[hbw_pkg::HBW_ADDR_W-1:2];

    ////////////////////////////////////////////////////////////////////////
    // Write pairing and the buffer toward the core.

    hbw_pkg::hbw_wr_ent_t buf_ff [DEPTH];
    hbw_pkg::hbw_wr_ent_t push_ent;
    logic [PTR_W-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic [PTR_W:0] cnt_ff, nxt_cnt;
    logic push, pop;
    logic wr_pend_ff, nxt_wr_pend, wr_half_ff, nxt_wr_half;
    logic [15:0] wr_hold_ff, nxt_wr_hold;

    // A lone half waits in the holder; its partner completes the dword.
    always_comb begin
        nxt_wr_pend = wr_pend_ff;
        nxt_wr_half = wr_half_ff;
        nxt_wr_hold = wr_hold_ff;
        push = 1'b0;
        push_ent.dw_addr = host_addr[hbw_pkg::HBW_ADDR_W-1:2];
        push_ent.data = host_d_in;
        if (wr_go && !width16_ff) begin
            push = 1'b1;
        end else if (wr_go && !wr_pend_ff) begin
            nxt_wr_pend = 1'b1;
            nxt_wr_half = hi_sel;
            nxt_wr_hold = host_d_in[15:0];
        end else if (wr_go && wr_half_ff != hi_sel) begin
            push = 1'b1;
            nxt_wr_pend = 1'b0;
            push_ent.data = hi_sel ? {host_d_in[15:0], wr_hold_ff}
                : {wr_hold_ff, host_d_in[15:0]};
        end
        // A write to the half already held falls through unused.
    end

    // Two-entry buffer: a stalled core back-pressures the host port.
    assign pop = core_wr_valid && core_wr_ready;
    assign core_wr_valid = (cnt_ff != '0);
    assign core_wr_ent = buf_ff[rp_ff];
    assign host_wr_ready = (cnt_ff != (PTR_W+1)'(DEPTH));

    always_comb begin
        nxt_wp = push ? step_ptr(wp_ff) : wp_ff;
        nxt_rp = pop ? step_ptr(rp_ff) : rp_ff;
        nxt_cnt = cnt_ff + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
            wr_pend_ff <= 1'b0;
            wr_half_ff <= 1'b0;
            wr_hold_ff <= 16'h0000;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
            wr_pend_ff <= nxt_wr_pend;
            wr_half_ff <= nxt_wr_half;
            wr_hold_ff <= nxt_wr_hold;
        end
    end

    // Buffer storage needs no reset; the count guards its contents.
    always_ff @(posedge ref_clk) begin
        if (push) begin
            buf_ff[wp_ff] <= push_ent;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read splitting.

    logic rd_pend_ff, nxt_rd_pend, rd_half_ff, nxt_rd_half;
    logic [31:0] rd_hold_ff, nxt_rd_hold, rdata_ff, nxt_rdata;
    logic ack_ff, nxt_ack;

    // The whole dword is snapped on the first half so both halves agree.
    always_comb begin
        nxt_rd_pend = rd_pend_ff;
        nxt_rd_half = rd_half_ff;
        nxt_rd_hold = rd_hold_ff;
        nxt_rdata = rdata_ff;
        nxt_ack = rd_go;
        if (rd_go && !width16_ff) begin
            nxt_rdata = core_rd_data;
        end else if (rd_go && !rd_pend_ff) begin
            nxt_rd_pend = 1'b1;
            nxt_rd_half = hi_sel;
            nxt_rd_hold = core_rd_data;
            nxt_rdata = {16'h0000, hi_sel ? core_rd_data[31:16]
                : core_rd_data[15:0]};
        end else if (rd_go && rd_half_ff != hi_sel) begin
            nxt_rd_pend = 1'b0;
            nxt_rdata = {16'h0000, hi_sel ? rd_hold_ff[31:16]
                : rd_hold_ff[15:0]};
        end else if (rd_go) begin
            // Repeated half: answer invalid and start over on the next read.
            nxt_rd_pend = 1'b0;
            nxt_rdata = {16'h0000, hbw_pkg::HALF_INVALID};
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_pend_ff <= 1'b0;
            rd_half_ff <= 1'b0;
            rd_hold_ff <= hbw_pkg::DWORD_RESET;
            rdata_ff <= hbw_pkg::DWORD_RESET;
            ack_ff <= 1'b0;
        end else begin
            rd_pend_ff <= nxt_rd_pend;
            rd_half_ff <= nxt_rd_half;
            rd_hold_ff <= nxt_rd_hold;
            rdata_ff <= nxt_rdata;
            ack_ff <= nxt_ack;
        end
    end

    // Lanes are driven only in the answer cycle; upper lanes never narrow.
    assign host_d_out = rdata_ff;
    assign host_rd_ack = ack_ff;
    assign host_d_oe_lo = ack_ff;
    assign host_d_oe_hi = ack_ff && !width16_ff;

    ////////////////////////////////////////////////////////////////////////
    // Network transmit serialiser and receive assembler.

    hbw_pkg::hbw_tx_state_t tx_st_ff, nxt_tx_st;
    logic [31:0] tx_dw_ff, nxt_tx_dw;
    logic rx_lo_seen_ff, nxt_rx_lo_seen, rx_v_ff, nxt_rx_v;
    logic [31:0] rx_dw_ff, nxt_rx_dw;

    // The low word always leaves first, whatever the host mapping was.
    always_comb begin
        nxt_tx_st = tx_st_ff;
        nxt_tx_dw = tx_dw_ff;
        case (tx_st_ff)
            hbw_pkg::TX_IDLE: begin
                if (tx_dw_valid) begin
                    nxt_tx_dw = tx_dw;
                    nxt_tx_st = hbw_pkg::TX_LOW;
                end
            end
            hbw_pkg::TX_LOW: begin
                if (tx_hw_ready) begin
                    nxt_tx_st = hbw_pkg::TX_HIGH;
                end
            end
            hbw_pkg::TX_HIGH: begin
                if (tx_hw_ready) begin
                    nxt_tx_st = hbw_pkg::TX_IDLE;
                end
            end
            default: nxt_tx_st = hbw_pkg::TX_IDLE;
        endcase
    end

    assign tx_dw_ready = (tx_st_ff == hbw_pkg::TX_IDLE);
    assign tx_hw_valid = (tx_st_ff != hbw_pkg::TX_IDLE);
    assign tx_hw = (tx_st_ff == hbw_pkg::TX_HIGH) ? tx_dw_ff[31:16]
        : tx_dw_ff[15:0];

    // First received word fills the low half of the dword.
    always_comb begin
        nxt_rx_lo_seen = rx_lo_seen_ff;
        nxt_rx_dw = rx_dw_ff;
        nxt_rx_v = 1'b0;
        if (rx_hw_valid && !rx_lo_seen_ff) begin
            nxt_rx_dw[15:0] = rx_hw;
            nxt_rx_lo_seen = 1'b1;
        end else if (rx_hw_valid) begin
            nxt_rx_dw[31:16] = rx_hw;
            nxt_rx_lo_seen = 1'b0;
            nxt_rx_v = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_st_ff <= hbw_pkg::TX_IDLE;
            tx_dw_ff <= hbw_pkg::DWORD_RESET;
            rx_lo_seen_ff <= 1'b0;
            rx_dw_ff <= hbw_pkg::DWORD_RESET;
            rx_v_ff <= 1'b0;
        end else begin
            tx_st_ff <= nxt_tx_st;
            tx_dw_ff <= nxt_tx_dw;
            rx_lo_seen_ff <= nxt_rx_lo_seen;
            rx_dw_ff <= nxt_rx_dw;
            rx_v_ff <= nxt_rx_v;
        end
    end

    assign rx_dw = rx_dw_ff;
    assign rx_dw_valid = rx_v_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_upper_quiet;
        width16_ff |-> !host_d_oe_hi && host_d_out[31:16] == 16'h0000;
    endproperty
    a_upper_quiet: assert property (p_upper_quiet)
        else $error("Upper lanes driven in 16-bit mode.");

    property p_strap_bit;
        // The strap lands at the first edge, so stability counts from the
        // edge after that one.
        (strap_done_ff && $past(strap_done_ff))
            |-> hardware_config_reg[hbw_pkg::HARDWARE_CONFIG_REG_WIDTH_BIT] == width16_ff
            && $stable(width16_ff);
    endproperty
    a_strap_bit: assert property (p_strap_bit)
        else $error("Width bit wrong or changed.");

    property p_rd_wide;
        (rd_go && !width16_ff) |=> host_rd_ack
            && host_d_out == $past(core_rd_data);
    endproperty
    a_rd_wide: assert property (p_rd_wide)
        else $error("Wide read data not passed whole.");

    property p_wr_pair;
        (wr_go && width16_ff && wr_pend_ff && wr_half_ff != hi_sel)
            |=> !wr_pend_ff && core_wr_valid;
    endproperty
    a_wr_pair: assert property (p_wr_pair)
        else $error("Write pair did not complete.");

    property p_wr_same;
        (wr_go && width16_ff && wr_pend_ff && wr_half_ff == hi_sel)
            |=> wr_pend_ff && $stable(wr_hold_ff) && $stable(wp_ff);
    endproperty
    a_wr_same: assert property (p_wr_same)
        else $error("Repeated half write was not discarded.");

    property p_rd_same;
        (rd_go && width16_ff && rd_pend_ff && rd_half_ff == hi_sel)
            |=> !rd_pend_ff && host_d_out[15:0] == hbw_pkg::HALF_INVALID;
    endproperty
    a_rd_same: assert property (p_rd_same)
        else $error("Repeated half read not restarted.");

    property p_swap_lane;
        (rd_go && swap && !rd_pend_ff && !host_addr[1])
            |=> host_d_out[15:0] == $past(core_rd_data[31:16]);
    endproperty
    a_swap_lane: assert property (p_swap_lane)
        else $error("Swapped lane mapping wrong.");

    property p_plain_lane;
        (rd_go && width16_ff && !swap && !rd_pend_ff && !host_addr[1])
            |=> host_d_out[15:0] == $past(core_rd_data[15:0]);
    endproperty
    a_plain_lane: assert property (p_plain_lane)
        else $error("Default lane mapping wrong.");

    property p_tx_low_first;
        (tx_dw_valid && tx_dw_ready) |=> tx_hw_valid
            && tx_hw == $past(tx_dw[15:0]);
    endproperty
    a_tx_low_first: assert property (p_tx_low_first)
        else $error("Transmit did not start with low word.");

    property p_rx_low_first;
        (rx_hw_valid && rx_lo_seen_ff) |=> rx_dw_valid
            && rx_dw[31:16] == $past(rx_hw);
    endproperty
    a_rx_low_first: assert property (p_rx_low_first)
        else $error("Receive word placed in wrong half.");

    property p_buf_full;
        (host_wr && !host_wr_ready) |=> $stable(wp_ff) && $stable(wr_pend_ff)
            && $stable(wr_hold_ff);
    endproperty
    a_buf_full: assert property (p_buf_full)
        else $error("Write taken while buffer full.");

endmodule : hbw_host_port

`default_nettype wire

// [hbw_core_model.sv]
// Behavioural core side of the host port: a dword store that takes buffer
// entries and answers read addresses in the same cycle.
// Assumes the host port's valid and ready write handshake on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module hbw_core_model (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Bench control: high holds the write side off.
    input wire logic stall,
    // Write side.
    input wire logic core_wr_valid,
    output logic core_wr_ready,
    input wire hbw_pkg::hbw_wr_ent_t core_wr_ent,
    // Read side.
    input wire logic [hbw_pkg::HBW_DW_ADDR_W-1:0] core_rd_addr,
    output logic [31:0] core_rd_data
);
    logic [31:0] mem [64] = '{default: 32'h00000000};

    ////////////////////////////////////////////////////////////////////////
    // Ready changes only just after an edge, so a stall is seen whole.
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_wr_ready <= 1'b0;
        end else begin
            core_wr_ready <= !stall;
            if (core_wr_valid && core_wr_ready) begin
                mem[core_wr_ent.dw_addr] <= core_wr_ent.data;
            end
        end
    end

    // The store answers at once, as the port expects of the core.
    assign core_rd_data = mem[core_rd_addr];
endmodule : hbw_core_model
`default_nettype wire

// [host_bus_width_word_swap_bench.sv]
// Self-checking bench of the host port: width strap, half-word pairing,
// word swap lanes, write buffer stall and network word order.
// Assumes hbw_host_port and hbw_core_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module host_bus_width_word_swap_bench;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic width_strap_pin = 1'b1;
    logic [31:0] word_swap_reg = 32'h00000000;
    logic [31:0] hardware_config_reg;
    logic host_wr = 1'b0;
    logic host_rd = 1'b0;
    logic [7:0] host_addr = 8'h00;
    logic [31:0] host_d_in = 32'h00000000;
    logic host_wr_ready, host_d_oe_lo, host_d_oe_hi, host_rd_ack;
    logic [31:0] host_d_out, core_rd_data, rx_dw;
    logic core_wr_valid, core_wr_ready, tx_dw_ready, tx_hw_valid;
    logic rx_dw_valid, stall = 1'b0;
    hbw_pkg::hbw_wr_ent_t core_wr_ent;
    logic [hbw_pkg::HBW_DW_ADDR_W-1:0] core_rd_addr;
    logic tx_dw_valid = 1'b0;
    logic [31:0] tx_dw = 32'h00000000;
    logic tx_hw_ready = 1'b0;
    logic [15:0] tx_hw;
    logic rx_hw_valid = 1'b0;
    logic [15:0] rx_hw = 16'h0000;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;

    always #25 ref_clk = !ref_clk;

    hbw_host_port #(.DEPTH(2)) i_hbw_host_port (
        .ref_clk(ref_clk), .reset_n(reset_n),
        .width_strap_pin(width_strap_pin), .word_swap_reg(word_swap_reg),
        .hardware_config_reg(hardware_config_reg),
        .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
        .host_d_in(host_d_in), .host_wr_ready(host_wr_ready),
        .host_d_out(host_d_out), .host_d_oe_lo(host_d_oe_lo),
        .host_d_oe_hi(host_d_oe_hi), .host_rd_ack(host_rd_ack),
        .core_wr_valid(core_wr_valid), .core_wr_ready(core_wr_ready),
        .core_wr_ent(core_wr_ent), .core_rd_addr(core_rd_addr),
        .core_rd_data(core_rd_data), .tx_dw_valid(tx_dw_valid),
        .tx_dw_ready(tx_dw_ready), .tx_dw(tx_dw), .tx_hw_valid(tx_hw_valid),
        .tx_hw_ready(tx_hw_ready), .tx_hw(tx_hw), .rx_hw_valid(rx_hw_valid),
        .rx_hw(rx_hw), .rx_dw_valid(rx_dw_valid), .rx_dw(rx_dw)
    );

    hbw_core_model i_hbw_core_model (
        .ref_clk(ref_clk), .reset_n(reset_n), .stall(stall),
        .core_wr_valid(core_wr_valid), .core_wr_ready(core_wr_ready),
        .core_wr_ent(core_wr_ent), .core_rd_addr(core_rd_addr),
        .core_rd_data(core_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Verdict in one place, reached by the main sequence or the timeout.
    task automatic finish_test();
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // The whole run needs well under a thousand cycles.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            finish_test();
        end
    end

    // Reset for five cycles; returns two edges after release, with the strap already caught.
    task automatic do_reset(logic strap);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        width_strap_pin <= strap;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask : do_reset

    // Write strobe held until an edge at which ready is high.
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic ok;
        @(posedge ref_clk);
        host_wr <= 1'b1;
        host_addr <= a;
        host_d_in <= d;
        for (int i = 0; i < 30; i++) begin
            @(negedge ref_clk);
            ok = host_wr_ready;
            @(posedge ref_clk);
            if (ok) break;
        end
        host_wr <= 1'b0;
    endtask : wr

    // Lets the buffer drain into the store, within a bounded wait.
    // The first wait lets a push at the calling edge show as valid.
    task automatic settle();
        @(negedge ref_clk);
        for (int i = 0; i < 20 && core_wr_valid !== 1'b0; i++) begin
            @(negedge ref_clk);
        end
    endtask : settle

    // One read strobe; the answer stands one cycle after the strobe edge.
    task automatic rd(logic [7:0] a, logic [31:0] exp, logic oe_hi);
        @(posedge ref_clk);
        host_rd <= 1'b1;
        host_addr <= a;
        @(posedge ref_clk);
        host_rd <= 1'b0;
        #1;
        chk("rd_ack", host_rd_ack, 32'h00000001);
        chk("rd_data", host_d_out, exp);
        chk("oe_lo", host_d_oe_lo, 32'h00000001);
        chk("oe_hi", host_d_oe_hi, oe_hi);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////
    // Pairs of halves in both orders, both mappings and a dropped repeat.
    // Upper lanes carry junk to show they are ignored in 16-bit mode.
    task automatic t_writes16();
        chk("hardware_config_reg", hardware_config_reg, 32'h00000004);
        wr(8'h04, 32'hFFFF1111);
        wr(8'h06, 32'hFFFF2222);
        word_swap_reg <= hbw_pkg::SWAP_ALL_ONES;
        wr(8'h0A, 32'hFFFF3333);
        wr(8'h08, 32'hFFFF4444);
        word_swap_reg <= 32'hFFFFFFFE;
        wr(8'h0C, 32'hFFFF5555);
        wr(8'h0C, 32'hFFFF6666);
        wr(8'h0E, 32'hFFFF7777);
        settle();
        chk("mem1", i_hbw_core_model.mem[1], 32'h22221111);
        chk("mem2", i_hbw_core_model.mem[2], 32'h44443333);
        chk("mem3", i_hbw_core_model.mem[3], 32'h77775555);
    endtask : t_writes16

    // Reads under both mappings and a repeated half that restarts pairing.
    task automatic t_reads16();
        word_swap_reg <= 32'h00000000;
        rd(8'h04, 32'h00001111, 1'b0);
        rd(8'h06, 32'h00002222, 1'b0);
        word_swap_reg <= hbw_pkg::SWAP_ALL_ONES;
        rd(8'h06, 32'h00001111, 1'b0);
        rd(8'h04, 32'h00002222, 1'b0);
        word_swap_reg <= 32'h7FFFFFFF;
        rd(8'h0C, 32'h00005555, 1'b0);
        rd(8'h0C, 32'h00000000, 1'b0);
        rd(8'h0E, 32'h00007777, 1'b0);
        rd(8'h0C, 32'h00005555, 1'b0);
    endtask : t_reads16

    // A lone half before reset must not pair with a half after it.
    task automatic t_reset_pair();
        word_swap_reg <= 32'h00000000;
        wr(8'h10, 32'h0000AAAA);
        do_reset(1'b1);
        wr(8'h12, 32'h0000BBBB);
        wr(8'h10, 32'h0000CCCC);
        settle();
        chk("mem4", i_hbw_core_model.mem[4], 32'hBBBBCCCC);
    endtask : t_reset_pair

    // Transmit order with a stalling receiver on the network side.
    task automatic t_tx();
        @(posedge ref_clk);
        tx_dw_valid <= 1'b1;
        tx_dw <= 32'h9876ABCD;
        @(posedge ref_clk);
        tx_dw_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("tx_valid", tx_hw_valid, 32'h00000001);
        chk("tx_busy", tx_dw_ready, 32'h00000000);
        chk("tx_low", tx_hw, 32'h0000ABCD);
        @(posedge ref_clk);
        tx_hw_ready <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk("tx_high", tx_hw, 32'h00009876);
        @(posedge ref_clk);
        tx_hw_ready <= 1'b0;
        #1;
        chk("tx_done", tx_hw_valid, 32'h00000000);
        chk("tx_free", tx_dw_ready, 32'h00000001);
    endtask : t_tx

    // The first received half lands in the low half of the dword.
    task automatic t_rx();
        @(posedge ref_clk);
        rx_hw_valid <= 1'b1;
        rx_hw <= 16'h1357;
        @(posedge ref_clk);
        rx_hw <= 16'h2468;
        @(posedge ref_clk);
        rx_hw_valid <= 1'b0;
        #1;
        chk("rx_valid", rx_dw_valid, 32'h00000001);
        chk("rx_dw", rx_dw, 32'h24681357);
    endtask : t_rx

    // Wide bus: swap ignored, full lanes, buffer filled until it refuses.
    task automatic t_wide();
        do_reset(1'b0);
        chk("hw_cfg32", hardware_config_reg, 32'h00000000);
        word_swap_reg <= hbw_pkg::SWAP_ALL_ONES;
        stall <= 1'b1;
        wr(8'h20, 32'h12345678);
        wr(8'h24, 32'h0BADF00D);
        @(negedge ref_clk);
        chk("wr_ready_full", host_wr_ready, 32'h00000000);
        chk("wr_valid_full", core_wr_valid, 32'h00000001);
        // A strobe while full must be refused and never reach the store.
        @(posedge ref_clk);
        host_wr <= 1'b1;
        host_addr <= 8'h28;
        host_d_in <= 32'h5A5A5A5A;
        @(posedge ref_clk);
        host_wr <= 1'b0;
        stall <= 1'b0;
        settle();
        chk("wr_empty", core_wr_valid, 32'h00000000);
        chk("mem8", i_hbw_core_model.mem[8], 32'h12345678);
        chk("mem9", i_hbw_core_model.mem[9], 32'h0BADF00D);
        chk("mem10", i_hbw_core_model.mem[10], 32'h00000000);
        rd(8'h20, 32'h12345678, 1'b1);
    endtask : t_wide

    initial begin
        do_reset(1'b1);
        t_writes16();
        t_reads16();
        t_reset_pair();
        t_tx();
        t_rx();
        t_wide();
        finish_test();
    end
endmodule : host_bus_width_word_swap_bench
`default_nettype wire
